// ==== logic/cml_macrocell_array.sv ====
// Macrocell array with switch matrix, foldback, keepers, power control and APB config
// Summary of operation
// - Any of a macrocell's five product terms may feed its OR sum.
// - OR sum accepts cascade from neighbour, chains of eight give forty terms.
// - XOR takes OR sum and a product term, constant one or zero.
// - XOR with register feedback emulates toggle and JK storage.
// - Storage data comes from XOR, a dedicated product term, or the pin.
// - Storage acts as D, T, JK, SR flip-flop or flow-through latch.
// - Latch passes data while clock high, holds while clock low.
// - Clock is one of three global lines or a product term.
// - Flip-flop modes update only on the selected clock's rising edge.
// - With a global clock, a low enable term makes every edge ignored.
// - Clear is global line, product term, their OR, or off.
// - Preset is a product term or off.
// - Pin output and buried feedback each pick registered or combinatorial.
// - Output enable from two enable pins true or inverted, a pin or macrocell.
// - Each I/O is input, output or both; logic stays usable as input.
// - Global bus carries pins and all 32 feedbacks; matrix picks 40 per block.
// - Inverted product term goes to a four-macrocell region bus, nine-term sums.
// - With keeper on, an undriven pin holds its last driven level.
// - Optional standby is entered while no input transitions and left on activity.
// - With power-down on, either pin high freezes logic and enabled outputs.
// - During power-down, pin transitions are ignored until the pin goes low.
// - Power-down pins serve no logic I/O but their macrocells still work.
// - Reset initialises every storage element; outputs then follow their polarity.
//
// Decided for this implementation: the register offsets and the APB slave port.
module cml_macrocell_array (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  global_clock_lines,
    input  wire logic        global_clear_line,
    input  wire logic [1:0]  enable_pins,
    input  wire logic [31:0] io_in,
    input  wire logic [31:0] io_undriven,
    output logic      [31:0] io_out,
    output logic      [31:0] io_oe_n
);
    localparam int N = cml_pkg::NUM_MC;

    logic [31:0]                cfg_q [N][cml_pkg::MC_WORDS];
    logic [6:0]                 sw_sel_q [cml_pkg::NUM_BLK][cml_pkg::SW_W];
    logic [cml_pkg::SW_W-1:0]   sw_vec [cml_pkg::NUM_BLK];
    logic [cml_pkg::GBUS_W-1:0] gbus_q;
    logic [cml_pkg::IN_W-1:0]   in_snap;
    logic [cml_pkg::IN_W-1:0]   in_prev_q;
    logic [N-1:0]               fold_q;
    logic [N-1:0]               fold_w;
    logic [N-1:0]               q_q;
    logic [N-1:0]               clkp_q;
    logic [N-1:0]               keep_q;
    logic [N-1:0]               io_out_q;
    logic [N-1:0]               io_oe_n_q;
    logic [N-1:0]               sum_w;
    logic [N-1:0]               xo_w;
    logic [N-1:0]               q_eff_w;
    logic [N-1:0]               fb_w;
    logic [N-1:0]               out_w;
    logic [N-1:0]               oe_w;
    logic [N-1:0]               pin_lvl;
    logic [N-1:0]               clr_w;
    logic [N-1:0]               set_w;
    logic [N-1:0]               upd_w;
    logic [N-1:0]               nxt_w;
    logic [N-1:0]               cur_w;
    logic [N-1:0]               din_w;
    logic [N-1:0]               ce_w;
    logic                       run_q;
    logic                       keep_en_q;
    logic                       stby_en_q;
    logic                       pd_en_q;
    logic                       stby_q;
    logic                       pd_act;
    logic                       adv;
    logic [31:0]                prdata_q;
    logic                       err_q;
    logic [31:0]                rdata;
    logic                       sw_hit;
    logic                       mc_hit;
    logic                       ctl_hit;
    logic                       ro_hit;
    logic                       setup;
    logic                       wr;
    logic                       cfg_wr;
    logic [4:0]                 mc_i;
    logic [4:0]                 w_i;
    logic                       b_i;
    logic [5:0]                 k_i;

    // Picks one of the five terms; unused index codes read as a dead term
    function automatic logic cml_pick(input logic [4:0] v, input logic [2:0] i);
        cml_pick = (i < 3'(cml_pkg::NUM_PT)) ? v[i] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Power state
    assign pd_act = pd_en_q & (io_in[cml_pkg::PDA_PIN] | io_in[cml_pkg::PDB_PIN]);
    // Freezing every logic flop, edge detectors included, makes pin activity invisible
    assign adv = run_q & ~pd_act;
    assign in_snap = {io_in, enable_pins, global_clear_line, global_clock_lines};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev_q <= '0;
            stby_q    <= 1'b0;
        end else if (clk_en) begin
            in_prev_q <= in_snap;
            stby_q    <= stby_en_q & (in_snap == in_prev_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Global bus and region bus, registered to break feedback loops (one cycle latency)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gbus_q <= '0;
            fold_q <= '0;
        end else if (clk_en && adv) begin
            gbus_q <= {fb_w, pin_lvl, enable_pins, global_clear_line, global_clock_lines};
            fold_q <= fold_w;
        end
    end

    for (genvar b = 0; b < cml_pkg::NUM_BLK; b++) begin : g_blk
        for (genvar k = 0; k < cml_pkg::SW_W; k++) begin : g_sw
            assign sw_vec[b][k] = (sw_sel_q[b][k] < 7'(cml_pkg::GBUS_W)) ?
                                  gbus_q[sw_sel_q[b][k]] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Macrocells
    for (genvar g = 0; g < N; g++) begin : g_mc
        localparam int BLK = g / cml_pkg::BLK_MC;
        localparam int RB  = (g / cml_pkg::REGION) * cml_pkg::REGION;
        logic [31:0]                 c1;
        logic [31:0]                 c2;
        logic [cml_pkg::PT_IN_W-1:0] pin;
        logic [cml_pkg::NUM_PT-1:0]  pt;
        logic                        casc;
        logic                        xb;
        logic                        kin;
        logic [1:0]                  csel;
        cml_pkg::cml_ff_mode_t       mode;
        cml_pkg::cml_d_src_t         dsrc;

        assign c1   = cfg_q[g][cml_pkg::CW1];
        assign c2   = cfg_q[g][cml_pkg::CW2];
        assign mode = cml_pkg::cml_ff_mode_t'(c1[cml_pkg::F_MODE +: 3]);
        assign dsrc = cml_pkg::cml_d_src_t'(c1[cml_pkg::F_DSRC +: 2]);
        assign csel = c1[cml_pkg::F_CSEL +: 2];
        assign pin  = {fold_q[RB +: cml_pkg::REGION], sw_vec[BLK]};

        for (genvar p = 0; p < cml_pkg::NUM_PT; p++) begin : g_pt
            logic [cml_pkg::PT_IN_W-1:0] tm;
            logic [cml_pkg::PT_IN_W-1:0] cm;
            assign tm = {cfg_q[g][3*p+2][11:0], cfg_q[g][3*p]};
            assign cm = {cfg_q[g][3*p+2][27:16], cfg_q[g][3*p+1]};
            assign pt[p] = &((~tm | pin) & (~cm | ~pin));
        end

        // Chains restart every eight cells so no sum exceeds forty terms
        if (g % cml_pkg::CHAIN == 0) begin : g_head
            assign casc = 1'b0;
        end else begin : g_link
            assign casc = sum_w[g-1];
        end
        assign sum_w[g] = (|(pt & c1[cml_pkg::F_OR +: cml_pkg::NUM_PT])) |
                          (c1[cml_pkg::F_CASC] & casc);

        always_comb begin
            unique case (cml_pkg::cml_xor_src_t'(c1[cml_pkg::F_XM +: 2]))
                cml_pkg::CML_XOR_PT:   xb = cml_pick(pt, c1[cml_pkg::F_XPT +: 3]);
                cml_pkg::CML_XOR_ONE:  xb = 1'b1;
                cml_pkg::CML_XOR_ZERO: xb = 1'b0;
                cml_pkg::CML_XOR_FB:   xb = q_eff_w[g];
            endcase
        end
        assign xo_w[g] = sum_w[g] ^ xb;
        assign kin     = cml_pick(pt, c1[cml_pkg::F_DPT +: 3]);
        assign din_w[g] = (dsrc == cml_pkg::CML_D_PT)  ? kin :
                          (dsrc == cml_pkg::CML_D_PIN) ? pin_lvl[g] : xo_w[g];

        assign cur_w[g] = (csel == cml_pkg::CSEL_PT) ? cml_pick(pt, c1[cml_pkg::F_CPT +: 3]) :
                          global_clock_lines[csel];
        assign ce_w[g] = (csel == cml_pkg::CSEL_PT) || !c1[cml_pkg::F_CE] ||
                         cml_pick(pt, c1[cml_pkg::F_CEPT +: 3]);
        assign clr_w[g] = (c1[cml_pkg::F_CLR] & global_clear_line) |
                          (c1[cml_pkg::F_CLR+1] & cml_pick(pt, c2[cml_pkg::F_CLRPT +: 3]));
        assign set_w[g] = c1[cml_pkg::F_SET] & cml_pick(pt, c2[cml_pkg::F_SETPT +: 3]);

        always_comb begin
            unique case (mode)
                cml_pkg::CML_FF_D:     nxt_w[g] = din_w[g];
                cml_pkg::CML_FF_T:     nxt_w[g] = q_q[g] ^ din_w[g];
                cml_pkg::CML_FF_JK:    nxt_w[g] = (din_w[g] & ~q_q[g]) | (~kin & q_q[g]);
                cml_pkg::CML_FF_SR:    nxt_w[g] = (din_w[g] & ~kin) | (q_q[g] & ~(kin & ~din_w[g]));
                cml_pkg::CML_FF_LATCH: nxt_w[g] = din_w[g];
                default:               nxt_w[g] = din_w[g];
            endcase
        end
        assign upd_w[g] = (mode == cml_pkg::CML_FF_LATCH) ? cur_w[g] :
                          (cur_w[g] & ~clkp_q[g] & ce_w[g]);
        // Clear beats preset, both beat the clock
        assign q_eff_w[g] = clr_w[g] ? 1'b0 : (set_w[g] | q_q[g]);
        assign out_w[g] = c2[cml_pkg::F_OREG]  ? q_eff_w[g] : xo_w[g];
        assign fb_w[g]  = c2[cml_pkg::F_FBREG] ? q_eff_w[g] : xo_w[g];
        assign fold_w[g] = ~cml_pick(pt, c2[cml_pkg::F_FOLD +: 3]);

        always_comb begin
            unique case (cml_pkg::cml_oe_sel_t'(c2[cml_pkg::F_OESEL +: 3]))
                cml_pkg::CML_OE_OFF: oe_w[g] = 1'b0;
                cml_pkg::CML_OE_ON:  oe_w[g] = 1'b1;
                cml_pkg::CML_OE_A:   oe_w[g] = enable_pins[0];
                cml_pkg::CML_OE_A_N: oe_w[g] = ~enable_pins[0];
                cml_pkg::CML_OE_B:   oe_w[g] = enable_pins[1];
                cml_pkg::CML_OE_B_N: oe_w[g] = ~enable_pins[1];
                cml_pkg::CML_OE_PIN: oe_w[g] = pin_lvl[c2[cml_pkg::F_OEIDX +: 5]];
                cml_pkg::CML_OE_MC:  oe_w[g] = fb_w[c2[cml_pkg::F_OEIDX +: 5]];
            endcase
        end

        // Power-down pins lose their pin role only; the cell logic keeps running
        if (g == cml_pkg::PDA_PIN || g == cml_pkg::PDB_PIN) begin : g_pdpin
            assign pin_lvl[g] = pd_en_q ? 1'b0 :
                                (keep_en_q & io_undriven[g]) ? keep_q[g] : io_in[g];
        end else begin : g_iopin
            assign pin_lvl[g] = (keep_en_q & io_undriven[g]) ? keep_q[g] : io_in[g];
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                q_q[g]    <= 1'b0;
                clkp_q[g] <= 1'b0;
            end else if (clk_en && adv) begin
                q_q[g]    <= clr_w[g] ? 1'b0 : set_w[g] ? 1'b1 : upd_w[g] ? nxt_w[g] : q_q[g];
                clkp_q[g] <= cur_w[g];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                keep_q[g] <= 1'b0;
            end else if (clk_en && !pd_act) begin
                keep_q[g] <= io_oe_n_q[g] ? pin_lvl[g] : io_out_q[g];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                io_out_q[g]  <= 1'b0;
                io_oe_n_q[g] <= 1'b1;
            end else if (clk_en && adv) begin
                io_out_q[g]  <= out_w[g];
                io_oe_n_q[g] <= ~(oe_w[g] & ~(pd_en_q & (g == cml_pkg::PDA_PIN ||
                                                        g == cml_pkg::PDB_PIN)));
            end
        end
    end

    assign io_out  = io_out_q;
    assign io_oe_n = io_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data and error captured in the setup cycle
    assign mc_i    = paddr[11:7];
    assign w_i     = paddr[6:2];
    assign b_i     = paddr[8];
    assign k_i     = paddr[7:2];
    assign sw_hit  = (paddr[15:9] == cml_pkg::SWM_BASE[15:9]) && (k_i < 6'(cml_pkg::SW_W));
    assign mc_hit  = (paddr[15:12] == cml_pkg::MC_BASE[15:12]) && (w_i < 5'(cml_pkg::MC_WORDS));
    assign ctl_hit = (paddr == cml_pkg::CTRL_OFS);
    assign ro_hit  = (paddr == cml_pkg::STATUS_OFS) || (paddr == cml_pkg::STATE_OFS) ||
                     (paddr == cml_pkg::PINS_OFS);
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign cfg_wr  = wr && (sw_hit || mc_hit) && !run_q;

    always_comb begin
        rdata = 32'h00000000;
        if (ctl_hit) begin
            rdata = {28'h0000000, pd_en_q, stby_en_q, keep_en_q, run_q};
        end else if (paddr == cml_pkg::STATUS_OFS) begin
            rdata = {29'h0, pd_act, stby_q, run_q};
        end else if (paddr == cml_pkg::STATE_OFS) begin
            rdata = q_q;
        end else if (paddr == cml_pkg::PINS_OFS) begin
            rdata = io_out_q;
        end else if (sw_hit) begin
            rdata = {25'h0, sw_sel_q[b_i][k_i]};
        end else if (mc_hit) begin
            rdata = cfg_q[mc_i][w_i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else if (clk_en && setup) begin
            prdata_q <= rdata;
            err_q    <= !(ctl_hit || ro_hit || sw_hit || mc_hit) || (pwrite && ro_hit) ||
                        (pwrite && run_q && (sw_hit || mc_hit));
        end
    end

    assign pready  = clk_en;
    assign prdata  = prdata_q;
    assign pslverr = psel & penable & err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q     <= cml_pkg::CTRL_RST[cml_pkg::B_RUN];
            keep_en_q <= cml_pkg::CTRL_RST[cml_pkg::B_KEEP];
            stby_en_q <= cml_pkg::CTRL_RST[cml_pkg::B_STBY];
            pd_en_q   <= cml_pkg::CTRL_RST[cml_pkg::B_PD];
        end else if (clk_en && wr && ctl_hit) begin
            run_q     <= pwdata[cml_pkg::B_RUN];
            keep_en_q <= pwdata[cml_pkg::B_KEEP];
            stby_en_q <= pwdata[cml_pkg::B_STBY];
            pd_en_q   <= pwdata[cml_pkg::B_PD];
        end
    end

    // Config is only writable while stopped, so the array never sees a half-changed cell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int m = 0; m < N; m++) begin
                for (int w = 0; w < cml_pkg::MC_WORDS; w++) begin
                    cfg_q[m][w] <= cml_pkg::CFG_RST;
                end
            end
            for (int b = 0; b < cml_pkg::NUM_BLK; b++) begin
                for (int k = 0; k < cml_pkg::SW_W; k++) begin
                    sw_sel_q[b][k] <= 7'h00;
                end
            end
        end else if (clk_en && cfg_wr) begin
            if (mc_hit) begin
                cfg_q[mc_i][w_i] <= pwdata;
            end else begin
                sw_sel_q[b_i][k_i] <= pwdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on macrocell 0, the keeper of pin 1 and the shared state
    default clocking cml_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic lat0;
    assign lat0 = (g_mc[0].mode == cml_pkg::CML_FF_LATCH);

    a_clear_first: assert property ((clk_en && adv && clr_w[0]) |=> !q_q[0])
        else $error("clear did not force state low");
    a_preset_sets: assert property ((clk_en && adv && set_w[0] && !clr_w[0]) |=> q_q[0])
        else $error("preset did not force state high");
    a_edge_only: assert property ((clk_en && adv && !upd_w[0] && !clr_w[0] && !set_w[0])
        |=> $stable(q_q[0]))
        else $error("state changed without an update");
    a_ce_blocks: assert property ((!ce_w[0] && !lat0) |-> !upd_w[0])
        else $error("edge taken with enable low");
    a_latch_pass: assert property ((clk_en && adv && lat0 && cur_w[0] && !clr_w[0] && !set_w[0])
        |=> (q_q[0] == $past(din_w[0])))
        else $error("latch did not pass data");
    a_xor_polarity: assert property ((g_mc[0].c1[cml_pkg::F_XM +: 2] == cml_pkg::CML_XOR_ONE)
        |-> (xo_w[0] == ~sum_w[0]))
        else $error("polarity inversion wrong");
    a_pd_hold: assert property (pd_act |=> ($stable(io_out) && $stable(io_oe_n) && $stable(q_q)))
        else $error("outputs moved in power-down");
    a_pd_pins: assert property (pd_en_q |-> (!pin_lvl[cml_pkg::PDA_PIN] &&
        !pin_lvl[cml_pkg::PDB_PIN]))
        else $error("power-down pin used as logic input");
    a_cfg_locked: assert property (run_q |=> $stable(cfg_q[0][cml_pkg::CW1]))
        else $error("config changed while running");
    a_keep_level: assert property ((keep_en_q && io_undriven[1]) |-> (pin_lvl[1] == keep_q[1]))
        else $error("keeper level not used");

    c_clock_update: cover property (clk_en && adv && upd_w[0] && !lat0);
    c_clear_and_set: cover property (clk_en && adv && clr_w[0] && set_w[0]);
    c_powerdown: cover property (pd_act ##1 !pd_act);
endmodule

// ==== logic/cml_pkg.sv ====
// Shared constants, field layout and types for the macrocell array
package cml_pkg;
    localparam int NUM_MC  = 32;
    localparam int NUM_PT  = 5;
    localparam int SW_W    = 40;
    localparam int REGION  = 4;
    localparam int CHAIN   = 8;
    localparam int BLK_MC  = 16;
    localparam int NUM_BLK = 2;
    localparam int GBUS_W  = 70;
    localparam int PT_IN_W = 44;
    localparam int IN_W    = 38;
    localparam int MC_WORDS = 17;
    localparam int CW1     = 15;
    localparam int CW2     = 16;
    localparam int PDA_PIN = 8;
    localparam int PDB_PIN = 24;
    // Byte addresses
    localparam logic [15:0] CTRL_OFS   = 16'h0000;
    localparam logic [15:0] STATUS_OFS = 16'h0004;
    localparam logic [15:0] STATE_OFS  = 16'h0008;
    localparam logic [15:0] PINS_OFS   = 16'h000C;
    localparam logic [15:0] SWM_BASE   = 16'h0400;
    localparam logic [15:0] MC_BASE    = 16'h1000;
    localparam logic [31:0] CTRL_RST   = 32'h00000000;
    localparam logic [31:0] CFG_RST    = 32'h00000000;
    localparam int B_RUN  = 0;
    localparam int B_KEEP = 1;
    localparam int B_STBY = 2;
    localparam int B_PD   = 3;
    // First control word
    localparam int F_OR   = 0;
    localparam int F_CASC = 5;
    localparam int F_XM   = 6;
    localparam int F_XPT  = 8;
    localparam int F_DSRC = 11;
    localparam int F_DPT  = 13;
    localparam int F_MODE = 16;
    localparam int F_CSEL = 19;
    localparam int F_CPT  = 21;
    localparam int F_CE   = 24;
    localparam int F_CEPT = 25;
    localparam int F_CLR  = 28;
    localparam int F_SET  = 30;
    // Second control word
    localparam int F_CLRPT = 0;
    localparam int F_SETPT = 3;
    localparam int F_FOLD  = 6;
    localparam int F_OREG  = 9;
    localparam int F_FBREG = 10;
    localparam int F_OESEL = 11;
    localparam int F_OEIDX = 14;
    localparam logic [1:0] CSEL_PT = 2'h3;
    typedef enum logic [1:0] {CML_XOR_PT, CML_XOR_ONE, CML_XOR_ZERO, CML_XOR_FB} cml_xor_src_t;
    typedef enum logic [1:0] {CML_D_XOR, CML_D_PT, CML_D_PIN} cml_d_src_t;
    typedef enum logic [2:0] {CML_FF_D, CML_FF_T, CML_FF_JK, CML_FF_SR, CML_FF_LATCH} cml_ff_mode_t;
    typedef enum logic [2:0] {CML_OE_OFF, CML_OE_ON, CML_OE_A, CML_OE_A_N,
                              CML_OE_B, CML_OE_B_N, CML_OE_PIN, CML_OE_MC} cml_oe_sel_t;
endpackage

// ==== testbench/cml_board_model.sv ====
// Board-side model driving the pins that the device leaves as inputs
module cml_board_model (
    input  wire logic        pclk,
    input  wire logic [31:0] drive_val,
    input  wire logic [31:0] drive_mask,
    input  wire logic [31:0] io_out,
    input  wire logic [31:0] io_oe_n,
    output logic      [31:0] io_in,
    output logic      [31:0] io_undriven
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] last_q;
    always @(posedge pclk) begin
        last_q <= io_in;
    end
    // A released pin flips every cycle, so only a keeper can hold it steady
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            io_undriven[i] = io_oe_n[i] & ~drive_mask[i];
            if (!io_oe_n[i])
                io_in[i] = io_out[i];
            else if (drive_mask[i])
                io_in[i] = drive_val[i];
            else
                io_in[i] = ~last_q[i];
        end
    end
endmodule

// ==== testbench/cpld_macrocell_logic_bench.sv ====
// Bench for the macrocell array: register access, logic paths and power-down
module cpld_macrocell_logic_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk;
    logic        presetn;
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  gclk;
    logic        gclr;
    logic [1:0]  en_pins;
    logic [31:0] io_in;
    logic [31:0] io_undriven;
    logic [31:0] io_out;
    logic [31:0] io_oe_n;
    logic [31:0] dval;
    logic [31:0] dmask;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          num_checks;
    int          cycles;
    cml_macrocell_array cml_macrocell_array_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_clock_lines(gclk),
        .global_clear_line(gclr), .enable_pins(en_pins), .io_in(io_in),
        .io_undriven(io_undriven), .io_out(io_out), .io_oe_n(io_oe_n));
    cml_board_model cml_board_model_inst (.pclk(pclk), .drive_val(dval),
        .drive_mask(dmask), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
        .io_undriven(io_undriven));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Config is refused while running, so every rewrite stops the array first
    task automatic cfg(input logic [31:0] w15, input logic [31:0] w16, input logic [31:0] c);
        apb(1'b1, 16'h0000, 32'h00000000);
        apb(1'b1, 16'h0400, 32'h00000007);
        apb(1'b1, 16'h1000, 32'h00000001);
        apb(1'b1, 16'h103C, w15);
        apb(1'b1, 16'h1040, w16);
        apb(1'b1, 16'h0000, c);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("oe_n", io_oe_n, 32'hFFFFFFFF);
        chk("out", io_out, 32'h00000000);
        apb(1'b0, 16'h0000, 32'h00000000);
        chk("ctrl", rd, 32'h00000000);
        apb(1'b0, 16'h0800, 32'h00000000);
        chk("unmapped", {31'h0, err}, 32'h00000001);
        apb(1'b1, 16'h0004, 32'h00000001);
        chk("ro write", {31'h0, err}, 32'h00000001);
    endtask
    task automatic t_comb();
        cfg(32'h00000081, 32'h00000800, 32'h00000001);
        dval[1] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("sum", {31'h0, io_out[0]}, 32'h00000001);
        chk("oe", {31'h0, io_oe_n[0]}, 32'h00000000);
        apb(1'b1, 16'h103C, 32'h00000000);
        chk("cfg lock", {31'h0, err}, 32'h00000001);
        cfg(32'h00000041, 32'h00000800, 32'h00000001);
        repeat (4) @(posedge pclk);
        chk("polarity", {31'h0, io_out[0]}, 32'h00000000);
    endtask
    task automatic t_dff();
        cfg(32'h10000081, 32'h00000A00, 32'h00000001);
        repeat (4) @(posedge pclk);
        chk("no edge", {31'h0, io_out[0]}, 32'h00000000);
        gclk[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("rise", {31'h0, io_out[0]}, 32'h00000001);
        dval[1] <= 1'b0;
        gclk[0] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("fall", {31'h0, io_out[0]}, 32'h00000001);
        gclr <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("clear", {31'h0, io_out[0]}, 32'h00000000);
        gclr <= 1'b0;
    endtask
    task automatic t_pd();
        dval[1] <= 1'b1;
        cfg(32'h00000081, 32'h00000800, 32'h00000009);
        repeat (4) @(posedge pclk);
        dval[8] <= 1'b1;
        repeat (2) @(posedge pclk);
        dval[1] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("frozen", {31'h0, io_out[0]}, 32'h00000001);
        dval[8] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("resume", {31'h0, io_out[0]}, 32'h00000000);
    endtask
    // Enable term index 5 is a dead term, so every clock edge must be lost
    task automatic t_more();
        cfg(32'h0B000081, 32'h00000A00, 32'h00000001);
        dval[1] <= 1'b1;
        repeat (2) @(posedge pclk);
        gclk[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("ce low", {31'h0, io_out[0]}, 32'h00000000);
        cfg(32'h00040081, 32'h00000A00, 32'h00000001);
        repeat (4) @(posedge pclk);
        chk("latch pass", {31'h0, io_out[0]}, 32'h00000001);
        gclk[0] <= 1'b0;
        dval[1] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("latch hold", {31'h0, io_out[0]}, 32'h00000001);
        cfg(32'h00000081, 32'h00000800, 32'h00000003);
        dval[1] <= 1'b1;
        repeat (4) @(posedge pclk);
        dmask[1] <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("keep a", {31'h0, io_out[0]}, 32'h00000001);
        @(posedge pclk);
        chk("keep b", {31'h0, io_out[0]}, 32'h00000001);
        dmask[1] <= 1'b1;
        gclr <= 1'b1;
        cfg(32'h50000081, 32'h00000A08, 32'h00000005);
        repeat (2) @(posedge pclk);
        chk("clear wins", {31'h0, io_out[0]}, 32'h00000000);
        gclr <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("preset", {31'h0, io_out[0]}, 32'h00000001);
        apb(1'b0, 16'h0004, 32'h00000000);
        chk("standby", rd, 32'h00000003);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, gclr} = 5'h00;
        {paddr, pwdata, dval, gclk, en_pins} = 85'h0;
        dmask = 32'hFFFFFFFF;
        {fails, num_checks, cycles} = 96'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_comb();
        t_dff();
        t_pd();
        t_more();
        end_sim();
    end
    // Whole run needs a few hundred cycles; a hang ends it here
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end
endmodule
